// [nmt_command_sender.v]
`timescale 1ns/1ps
`default_nettype none
`include "nmt_sender_defines.vh"

module nmt_command_sender
#(
  parameter SLOT_COUNT_W = 16       // width of slot number input
)
(
  // clock and reset
  input  wire                    ref_clk,
  input  wire                    rst,
  // request from the master logic
  input  wire                    start,
  input  wire [SLOT_COUNT_W-1:0] slot_number,
  input  wire [15:0]             remote_node_address,
  input  wire [15:0]             service_code,
  input  wire                    abort_cmd,
  // handshake back to the master logic
  output reg                     busy,
  output reg                     done,
  output reg                     error,
  output reg                     aborted,
  output reg  [15:0]             error_code_word,
  // command frame towards the bus controller
  output reg                     frame_valid,
  input  wire                    frame_ready,
  output reg  [10:0]             frame_id,
  output reg  [3:0]              frame_len,
  output wire [7:0]              frame_byte,
  output wire                    frame_byte_last,
  input  wire                    frame_byte_take,
  input  wire                    frame_sent,
  input  wire                    frame_fail,
  // which slot the command went to
  output reg  [SLOT_COUNT_W-1:0] slot_used
);

  // state register and its next value
  reg [4:0]  state;
  reg [4:0]  next_state;
  // previous start level for edge detection
  reg        start_q;
  // captured request
  reg [15:0] node_held;
  reg [15:0] svc_held;
  // one-cycle strobe that loads the byte shifter
  reg        load_frame;

  // start edges, one cycle wide
  wire start_rise = start & ~start_q;
  wire start_fall = ~start & start_q;

  // decode of the supported service codes
  function svc_known;
    input [15:0] code;
    begin
      case (code)
        // start and stop
        `SVC_START, `SVC_STOP: svc_known = 1'b1;
        // preop and resets
        `SVC_PREOP, `SVC_RESET_APP, `SVC_RESET_COMM: svc_known = 1'b1;
        // anything else is not a service
        default: svc_known = 1'b0;
      endcase
    end
  endfunction

  // range check of slot and node address
  function params_ok;
    input [SLOT_COUNT_W-1:0] slot;
    input [15:0]             node;
    begin
      // slot widened to 32 bits so any slot width up to 32 compares
      // node must lie in the usable address range
      params_ok = ({{(32-SLOT_COUNT_W){1'b0}}, slot} <= {16'h0000, `SLOT_MAX}) &&
                  (node >= `NODE_MIN) && (node <= `NODE_MAX);
    end
  endfunction

  // byte sequencer for the two data bytes
  // first byte shows one cycle after the load
  frame_shifter u_shift
  (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .load     (load_frame),
    .byte0    (svc_held[7:0]),
    .byte1    (node_held[7:0]),
    .advance  (frame_byte_take),
    .byte_out (frame_byte),
    .last     (frame_byte_last)
  );

  // next state decode
  always @*
  begin
    // hold the state unless a branch moves it
    next_state = state;
    case (state)
      // idle until start rises
      `ST_IDLE:
        if (start_rise)
          next_state = `ST_SEND;
      // waiting for the bus controller to take the frame
      `ST_SEND:
        // an abort wins over a ready in the same cycle
        if (abort_cmd)
          next_state = `ST_HOLD;
        else if (frame_ready)
          next_state = `ST_WAIT;
      // frame handed over, waiting for the outcome
      `ST_WAIT:
        if (abort_cmd || frame_sent || frame_fail)
          next_state = `ST_HOLD;
      `ST_HOLD:
        if (!start)
          next_state = `ST_CLEAR;
      // one idle step before the next run
      `ST_CLEAR:
        next_state = `ST_IDLE;
      // illegal code, back to idle
      default:
        next_state = `ST_IDLE;
    endcase
  end

  // main sequencer and outputs
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      // sequencer idle, no edge remembered
      state           <= `ST_IDLE;
      start_q         <= 1'b0;
      // request copies cleared
      node_held       <= 16'h0000;
      svc_held        <= 16'h0000;
      load_frame      <= 1'b0;
      // handshake flags low
      busy            <= 1'b0;
      done            <= 1'b0;
      error           <= 1'b0;
      aborted         <= 1'b0;
      // no result code and no frame offered
      error_code_word <= `ERR_NONE;
      frame_valid     <= 1'b0;
      frame_id        <= `NMT_FRAME_ID;
      frame_len       <= 4'h0;
      // no slot used yet
      slot_used       <= {SLOT_COUNT_W{1'b0}};
    end
    else
    begin
      // edge detector and loader strobe
      start_q    <= start;
      load_frame <= 1'b0;
      // default advance of the sequencer
      state      <= next_state;
      if (start_fall)
      begin
        done    <= 1'b0;
        error   <= 1'b0;
        aborted <= 1'b0;
      end
      // per-state work; later assignments win
      case (state)
        // waiting for a request
        `ST_IDLE:
        begin
          // launch only on a fresh rising edge
          if (start_rise)
          begin
            slot_used <= slot_number;
            node_held <= remote_node_address;
            svc_held  <= service_code;
            // clear stale results of a previous run
            done      <= 1'b0;
            error     <= 1'b0;
            aborted   <= 1'b0;
            if (!params_ok(slot_number, remote_node_address))
            begin
              error           <= 1'b1;
              error_code_word <= `ERR_BAD_PARAM;
              // skip the bus, show the result
              state           <= `ST_HOLD;
            end
            else if (!svc_known(service_code))
            begin
              error           <= 1'b1;
              error_code_word <= `ERR_UNSUPPORTED;
              // skip the bus, show the result
              state           <= `ST_HOLD;
            end
            // request valid: offer the frame
            else
            begin
              busy        <= 1'b1;
              frame_valid <= 1'b1;
              frame_id    <= `NMT_FRAME_ID;
              frame_len   <= `FRAME_BYTES;
              load_frame  <= 1'b1;
            end
          end
        end
        // frame offered to the bus controller
        `ST_SEND:
        begin
          // an abort wins over a ready
          if (abort_cmd)
          begin
            aborted     <= 1'b1;
            busy        <= 1'b0;
            frame_valid <= 1'b0;
          end
          // frame taken, drop the offer
          else if (frame_ready)
            frame_valid <= 1'b0;
        end
        // frame on its way, waiting for the outcome
        `ST_WAIT:
        begin
          // an abort overrides the outcome
          if (abort_cmd)
          begin
            aborted <= 1'b1;
            busy    <= 1'b0;
          end
          // the bus gave up on the frame
          else if (frame_fail)
          begin
            error           <= 1'b1;
            error_code_word <= `ERR_UNSUPPORTED;
            busy            <= 1'b0;
          end
          // frame delivered on the bus
          else if (frame_sent)
          begin
            done            <= 1'b1;
            error_code_word <= `ERR_NONE;
            busy            <= 1'b0;
          end
        end
        // result shown, waiting for start to drop
        `ST_HOLD:
        begin
          // start already low, clear next cycle
          if (!start)
          begin
            done    <= 1'b0;
            error   <= 1'b0;
            aborted <= 1'b0;
          end
        end
        // one step back towards idle
        `ST_CLEAR:
        begin
          // flags stay low on the way back
          done    <= 1'b0;
          error   <= 1'b0;
          aborted <= 1'b0;
        end
        // nothing to do in other states
        default:
        begin
          // keep busy as it is
          busy <= busy;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// [nmt_sender_defines.vh]
`ifndef NMT_SENDER_DEFINES_VH
`define NMT_SENDER_DEFINES_VH

// service codes carried in the command frame
`define SVC_START        16'h0001
`define SVC_STOP         16'h0002
`define SVC_PREOP        16'h0080
`define SVC_RESET_APP    16'h0081
`define SVC_RESET_COMM   16'h0082

// error code word values
`define ERR_NONE         16'h0000
`define ERR_BAD_PARAM    16'h000B
`define ERR_UNSUPPORTED  16'h000C

// parameter ranges
`define SLOT_MAX         16'h000B
`define NODE_MIN         16'h0001
`define NODE_MAX         16'h007F

// frame layout: identifier 0, two data bytes
`define NMT_FRAME_ID     11'h000
`define FRAME_BYTES      4'h2

// state codes, one-hot
`define ST_IDLE          5'h01
`define ST_SEND          5'h02
`define ST_WAIT          5'h04
`define ST_HOLD          5'h08
`define ST_CLEAR         5'h10

`endif

// [frame_shifter.v]
`timescale 1ns/1ps
`default_nettype none

// holds the two data bytes of a command frame and presents them one at a time
module frame_shifter
(
  // clock and reset
  input  wire        ref_clk,
  input  wire        rst,
  // load side
  input  wire        load,
  input  wire [7:0]  byte0,
  input  wire [7:0]  byte1,
  // read side
  input  wire        advance,
  output reg  [7:0]  byte_out,
  output reg         last
);

  // second byte waiting behind the output register
  reg [7:0] pending;

  // load both bytes, then shift the second forward
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      byte_out <= 8'h00;
      pending  <= 8'h00;
      last     <= 1'b0;
    end
    else if (load)
    begin
      byte_out <= byte0;
      pending  <= byte1;
      last     <= 1'b0;
    end
    else if (advance && !last)
    begin
      byte_out <= pending;
      last     <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// [nmt_command_sender_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module nmt_command_sender_checker
#(parameter SLOT_COUNT_W = 16)
(
  // watched ports
  input wire logic ref_clk, rst, start, busy, done, error, aborted, frame_valid,
  input wire logic [SLOT_COUNT_W-1:0] slot_number, slot_used,
  input wire logic [15:0] remote_node_address, error_code_word,
  input wire logic [10:0] frame_id,
  input wire logic [3:0] frame_len
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // nothing running or shown
  wire quiet = !(busy | done | error | aborted | frame_valid);
  // some field out of range
  wire bad = slot_number > 11 || remote_node_address < 1 || remote_node_address > 127;
  busy_start_a: assert property ($rose(busy) |-> $past(start) && !$past(start, 2) && frame_valid)
    else $error("busy without start edge");
  bad_param_a: assert property ($rose(start) && quiet && bad |=> error && !busy && error_code_word == 16'h000B)
    else $error("bad field not refused");
  slot_keep_a: assert property ($rose(busy) |-> slot_used == $past(slot_number))
    else $error("slot not taken at edge");
  done_ok_a: assert property ($rose(done) |-> !busy && error_code_word == 16'h0000)
    else $error("done with busy or code");
  fault_idle_a: assert property ($rose(error) || $rose(aborted) |-> !busy)
    else $error("busy left high");
  code_hold_a: assert property (!$rose(done) && !$rose(error) |-> $stable(error_code_word))
    else $error("code changed");
  flag_clear_a: assert property ((done || error || aborted) && !start |=> !(done || error || aborted))
    else $error("result flag stuck");
  frame_form_a: assert property (frame_valid |-> frame_id == 11'h000 && frame_len == 4'h2)
    else $error("frame header wrong");
endmodule
bind nmt_command_sender nmt_command_sender_checker #(.SLOT_COUNT_W(SLOT_COUNT_W)) checker_i (.ref_clk, .rst,
  .start, .busy, .done, .error, .aborted, .frame_valid, .slot_number, .slot_used, .remote_node_address,
  .error_code_word, .frame_id, .frame_len);
`default_nettype wire

// [can_node_model.sv]
`timescale 1ns/1ps
`default_nettype none
module can_node_model
(
  // clock, reset, frame in
  input wire logic ref_clk, rst, frame_valid, frame_byte_last, fail_mode,
  input wire logic [7:0] frame_byte,
  input wire logic [3:0] stall,
  // answers back
  output logic frame_ready, frame_byte_take, frame_sent, frame_fail,
  output logic [15:0] got
);
  logic [3:0] n; // step within a frame
  // slow or prompt acceptance, then byte pickup
  always @(posedge ref_clk)
  begin
    frame_ready <= 1'b0;
    frame_byte_take <= 1'b0;
    frame_sent <= 1'b0;
    frame_fail <= 1'b0;
    if (rst)
      n <= 4'h0;
    else if (n != 4'h0 || frame_valid)
    begin
      n <= n + 4'h1;
      frame_ready <= n == stall;
      frame_byte_take <= n == stall + 4'h2;
      if (n == stall + 4'h2)
        got[15:8] <= frame_byte;
      if (n == stall + 4'h4)
      begin
        got[7:0] <= frame_byte;
        frame_sent <= !fail_mode && frame_byte_last;
        frame_fail <= fail_mode;
        n <= 4'h0;
      end
    end
  end
endmodule
`default_nettype wire

// [nmt_command_sender_test.sv]
`timescale 1ns/1ps
`default_nettype none
module nmt_command_sender_test;
  logic ref_clk, rst, start, abort_cmd, fail_mode;
  logic [15:0] slot_number, remote_node_address, service_code;
  logic [3:0] stall;
  wire busy, done, error, aborted, frame_valid, frame_ready, frame_byte_last, frame_byte_take, frame_sent, frame_fail;
  wire [15:0] error_code_word, slot_used, got;
  wire [10:0] frame_id;
  wire [3:0] frame_len;
  wire [7:0] frame_byte;
  integer n_fail = 0, checks = 0, cyc = 0, i;
  logic [15:0] svc [0:4] = '{16'h0001, 16'h0002, 16'h0080, 16'h0081, 16'h0082};
  nmt_command_sender nmt_command_sender_i (.ref_clk, .rst, .start, .slot_number, .remote_node_address,
    .service_code, .abort_cmd, .busy, .done, .error, .aborted, .error_code_word, .frame_valid, .frame_ready,
    .frame_id, .frame_len, .frame_byte, .frame_byte_last, .frame_byte_take, .frame_sent, .frame_fail, .slot_used);
  can_node_model can_node_model_i (.ref_clk, .rst, .frame_valid, .frame_byte_last, .fail_mode, .frame_byte,
    .stall, .frame_ready, .frame_byte_take, .frame_sent, .frame_fail, .got);
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task chk(input string nm, input logic [15:0] s, e);
  begin
    checks = checks + 1;
    if (s !== e)
    begin
      n_fail = n_fail + 1;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  end
  endtask
  task close_out;
  begin
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  // one command; fl is {aborted, error, done} expected
  task run(input logic [15:0] s, n, v, input logic ab, dr, input logic [2:0] fl, input logic [15:0] ec);
  begin
    @(posedge ref_clk);
    slot_number <= s;
    remote_node_address <= n;
    service_code <= v;
    start <= 1'b1;
    @(posedge ref_clk);
    abort_cmd <= ab;
    start <= !dr;
    #1;
    while (!(done | error | aborted))
      @(posedge ref_clk) #1;
    chk("flags", {13'h0, aborted, error, done}, {13'h0, fl});
    chk("busy", {15'h0, busy}, 16'h0000);
    chk("code", error_code_word, ec);
    chk("slot", slot_used, s);
    if (fl == 3'h1)
      chk("frame", got, {v[7:0], n[7:0]});
    @(posedge ref_clk);
    start <= 1'b0;
    abort_cmd <= 1'b0;
    #1;
    if (dr)
      chk("late clear", {13'h0, aborted, error, done}, 16'h0000);
    repeat (14) @(posedge ref_clk);
    #1;
    chk("clear", {13'h0, aborted, error, done}, 16'h0000);
    $display("test done");
  end
  endtask
  always @(posedge ref_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      n_fail = n_fail + 1;
      close_out;
    end
  end
  initial
  begin
    rst = 1'b1;
    start = 1'b0;
    abort_cmd = 1'b0;
    fail_mode = 1'b0;
    stall = 4'h1;
    slot_number = 16'h0000;
    remote_node_address = 16'h0001;
    service_code = 16'h0001;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    for (i = 0; i < 5; i = i + 1)
    begin
      stall <= i[3:0] + 4'h1;
      run(i[0] ? 16'h000B : 16'h0000, i[0] ? 16'h007F : 16'h0001, svc[i], 1'b0, i == 4, 3'h1, 16'h0000);
    end
    run(16'h000C, 16'h0001, 16'h0001, 1'b0, 1'b0, 3'h2, 16'h000B);
    run(16'h0000, 16'h0000, 16'h0001, 1'b0, 1'b0, 3'h2, 16'h000B);
    run(16'h0000, 16'h0080, 16'h0002, 1'b0, 1'b0, 3'h2, 16'h000B);
    run(16'h0000, 16'h0001, 16'h0003, 1'b0, 1'b0, 3'h2, 16'h000C);
    fail_mode <= 1'b1;
    run(16'h0001, 16'h0002, 16'h0001, 1'b0, 1'b0, 3'h2, 16'h000C);
    fail_mode <= 1'b0;
    stall <= 4'h8;
    run(16'h0002, 16'h0003, 16'h0002, 1'b1, 1'b0, 3'h4, 16'h000C);
    run(16'h0003, 16'h0005, 16'h0081, 1'b0, 1'b0, 3'h1, 16'h0000);
    close_out;
  end
endmodule
`default_nettype wire
